// >>> sim/host_dim_model.sv
// host model: holds dim inputs low until the power-up reset has had time to finish
`timescale 1ns/1ps
module host_dim_model
#(
  parameter int PUR_CYC = 4
)
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic RESETN,
  // requests from the bench
  input  wire logic ab_req,
  input  wire logic c_req,
  // dim pins
  output logic      BANK_AB_DIM_INPUT,
  output logic      BANK_C_DIM_INPUT
);
  int   cnt_q;
  logic ready;
  // margin covers the two reset sync flops
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      cnt_q <= 0;
    else if (cnt_q < PUR_CYC + 4)
      cnt_q <= cnt_q + 1;
  end
  assign ready = (cnt_q >= PUR_CYC + 4);
  assign BANK_AB_DIM_INPUT = ab_req & ready;
  assign BANK_C_DIM_INPUT  = c_req & ready;
endmodule

// >>> sim/tb_led_mode_ctrl.sv
// self-checking bench for the led driver mode controller
`timescale 1ns/1ps
module tb_led_mode_ctrl;
  import led_ctrl_pkg::*;
  localparam int SD = 200;
  localparam int FC = 20;
  localparam int PC = 4;
  logic       CLK, RESETN, ab_req, c_req, UVLO, SUPPLY_OK_1X, ab, c, ce;
  logic [5:0] HEADROOM_LOW, CATHODE_EN, CATHODE_OE;
  logic [1:0] PUMP_MODE;
  logic       PUMP_ON, SHUTDOWN;
  int         bad_count, checks, n;
  host_dim_model #(.PUR_CYC(PC)) u_host_dim_model (.CLK(CLK), .RESETN(RESETN),
    .ab_req(ab_req), .c_req(c_req), .BANK_AB_DIM_INPUT(ab), .BANK_C_DIM_INPUT(c));
  led_mode_ctrl #(.SHUTDOWN_CYC(SD), .FILTER_CYC(FC), .PUR_CYC(PC)) u_led_mode_ctrl (
    .CLK(CLK), .RESETN(RESETN), .CE(ce), .BANK_AB_DIM_INPUT(ab),
    .BANK_C_DIM_INPUT(c), .UVLO(UVLO), .HEADROOM_LOW(HEADROOM_LOW),
    .SUPPLY_OK_1X(SUPPLY_OK_1X), .CATHODE_EN(CATHODE_EN), .CATHODE_OE(CATHODE_OE),
    .PUMP_MODE(PUMP_MODE), .PUMP_ON(PUMP_ON), .SHUTDOWN(SHUTDOWN));
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_enable();
    chk({5'h00, SHUTDOWN}, 6'h01);
    chk(CATHODE_OE, 6'h00);
    ab_req = 1'b1;
    tick(1);
    chk(CATHODE_EN, 6'h0F);
    chk({2'h0, PUMP_ON, SHUTDOWN, PUMP_MODE}, 6'h08);
    chk(CATHODE_OE, 6'h3F);
    c_req = 1'b1;
    tick(1);
    chk(CATHODE_EN, 6'h3F);
    ab_req = 1'b0;
    tick(1);
    chk(CATHODE_EN, 6'h30);
  endtask
  // waits for one step and checks the filter delay it took
  task automatic step(input logic [1:0] old, input logic [1:0] exp);
    n = 0;
    while (PUMP_MODE === old && n < FC + 5)
    begin
      tick(1);
      n++;
    end
    chk({4'h0, PUMP_MODE}, {4'h0, exp});
    chk({5'h00, n >= FC - 1 && n <= FC + 2}, 6'h01);
  endtask
  task automatic t_modes();
    // low headroom on a channel that is off must be ignored
    HEADROOM_LOW = 6'h01;
    tick(FC + 5);
    chk({4'h0, PUMP_MODE}, {4'h0, PM_1X});
    HEADROOM_LOW = 6'h10;
    step(PM_1X, PM_133X);
    step(PM_133X, PM_15X);
    step(PM_15X, PM_2X);
    tick(FC + 5);
    chk({4'h0, PUMP_MODE}, {4'h0, PM_2X});
    HEADROOM_LOW = 6'h00;
    SUPPLY_OK_1X = 1'b1;
    tick(2);
    chk({4'h0, PUMP_MODE}, {4'h0, PM_1X});
    SUPPLY_OK_1X = 1'b0;
  endtask
  task automatic t_timeout();
    c_req = 1'b0;
    tick(SD - 3);
    chk({5'h00, SHUTDOWN}, 6'h00);
    tick(7);
    chk({5'h00, SHUTDOWN}, 6'h01);
    chk(CATHODE_OE, 6'h00);
    ab_req = 1'b1;
    tick(1);
    chk(CATHODE_EN, 6'h0F);
    // input held high past the timeout: bank off, pump kept on
    tick(SD + 4);
    chk({CATHODE_EN[3:0], 1'b0, PUMP_ON}, 6'h01);
  endtask
  task automatic t_uvlo();
    UVLO = 1'b1;
    tick(2);
    chk({5'h00, SHUTDOWN}, 6'h01);
    chk(CATHODE_OE | CATHODE_EN, 6'h00);
    ab_req = 1'b0;
    c_req = 1'b1;
    tick(3);
    chk({CATHODE_EN[5:4], 3'h0, SHUTDOWN}, 6'h01);
    UVLO = 1'b0;
  endtask
  // enable low must hold off the wake-up that a high input asks for
  task automatic t_freeze();
    ce = 1'b0;
    tick(3);
    chk({5'h00, SHUTDOWN}, 6'h01);
    ce = 1'b1;
    tick(1);
    chk(CATHODE_EN, 6'h30);
    chk({5'h00, SHUTDOWN}, 6'h00);
  endtask
  initial
  begin
    bad_count = 0;
    checks = 0;
    ce = 1'b1;
    RESETN = 1'b0;
    ab_req = 1'b0;
    c_req = 1'b0;
    UVLO = 1'b0;
    SUPPLY_OK_1X = 1'b0;
    HEADROOM_LOW = 6'h00;
    tick(2);
    RESETN = 1'b1;
    tick(PC + 6);
    t_enable();
    t_modes();
    t_timeout();
    t_uvlo();
    t_freeze();
    tally_and_finish();
  end
  initial
  begin
    #40000;
    bad_count++;
    tally_and_finish();
  end
endmodule

// >>> verilog/led_ctrl_defs.svh
// timing and encoding constants for the led driver mode controller
`ifndef LED_CTRL_DEFS_SVH
`define LED_CTRL_DEFS_SVH
`define CLK_PERIOD_NS      8
`define SHUTDOWN_TIME_US   30000
`define FILTER_TIME_US     800
`define PUR_TIME_NS        10000
`define SHUTDOWN_CYCLES    ((`SHUTDOWN_TIME_US * 1000) / `CLK_PERIOD_NS)
`define FILTER_CYCLES      ((`FILTER_TIME_US * 1000) / `CLK_PERIOD_NS)
`define PUR_CYCLES         ((`PUR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W              22
`define PUR_W              11
`define CNT_ZERO           22'h000000
`define PUR_ZERO           11'h000
`define MODE_1X            2'h0
`define MODE_133X          2'h1
`define MODE_15X           2'h3
`define MODE_2X            2'h2
`endif

// >>> verilog/led_ctrl_pkg.sv
// types for the led driver mode controller
package led_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_SHUT  = 2'h1,
    ST_RUN   = 2'h3
  } ctrl_state_e;
  typedef enum logic [1:0] {
    PM_1X   = 2'h0,
    PM_133X = 2'h1,
    PM_15X  = 2'h3,
    PM_2X   = 2'h2
  } pump_mode_e;
endpackage

// >>> verilog/led_mode_ctrl.sv
// enable, shutdown timer and charge pump mode sequencing for a six channel led driver
`timescale 1ns/1ps
`include "led_ctrl_defs.svh"
module led_mode_ctrl
  import led_ctrl_pkg::*;
#(
  parameter int SHUTDOWN_CYC = `SHUTDOWN_CYCLES,
  parameter int FILTER_CYC   = `FILTER_CYCLES,
  parameter int PUR_CYC      = `PUR_CYCLES
)
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       CE,
  // host dimming inputs
  input  wire logic       BANK_AB_DIM_INPUT,
  input  wire logic       BANK_C_DIM_INPUT,
  // analog monitors
  input  wire logic       UVLO,
  input  wire logic [5:0] HEADROOM_LOW,
  input  wire logic       SUPPLY_OK_1X,
  // channel drive, order c2 c1 b2 b1 a2 a1
  output logic      [5:0] CATHODE_EN,
  output logic      [5:0] CATHODE_OE,
  // pump control
  output logic      [1:0] PUMP_MODE,
  output logic            PUMP_ON,
  output logic            SHUTDOWN
);
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  ctrl_state_e        state_q, state_d;
  pump_mode_e         mode_q, mode_d;
  logic [`CNT_W-1:0]  idle_q, idle_d;
  logic [`CNT_W-1:0]  ab_hold_q, ab_hold_d;
  logic [`CNT_W-1:0]  c_hold_q, c_hold_d;
  logic [`CNT_W-1:0]  filt_q, filt_d;
  logic [`PUR_W-1:0]  pur_q, pur_d;
  logic               ab_prev_q, ab_prev_d;
  logic               c_prev_q, c_prev_d;
  logic [5:0]         en_q, en_d;
  logic [5:0]         oe_q, oe_d;
  logic               ab_live, c_live, any_in, low_hr;
  logic [5:0]         bank_on;

  localparam logic [`CNT_W-1:0] SHUT_LIM = `CNT_W'(SHUTDOWN_CYC);
  localparam logic [`CNT_W-1:0] FILT_LIM = `CNT_W'(FILTER_CYC);
  localparam logic [`PUR_W-1:0] PUR_LIM  = `PUR_W'(PUR_CYC);

  // a stuck level stops its bank; a fresh edge revives it in the same cycle,
  // although the hold counter still shows the old saturated value on that edge
  assign ab_live = BANK_AB_DIM_INPUT
                   & ((BANK_AB_DIM_INPUT != ab_prev_q) | (ab_hold_q < SHUT_LIM));
  assign c_live  = BANK_C_DIM_INPUT
                   & ((BANK_C_DIM_INPUT != c_prev_q) | (c_hold_q < SHUT_LIM));

  // channels 5:4 belong to bank c, channels 3:0 to banks a and b
  for (genvar ch = 0; ch < 6; ch++)
  begin : g_chan
    assign bank_on[ch] = (ch >= 4) ? c_live : ab_live;
  end

  // headroom of a channel that is off says nothing about the pump
  assign low_hr = |(HEADROOM_LOW & bank_on);

  always_comb
  begin
    state_d   = state_q;
    mode_d    = mode_q;
    idle_d    = idle_q;
    ab_hold_d = ab_hold_q;
    c_hold_d  = c_hold_q;
    filt_d    = filt_q;
    pur_d     = pur_q;
    ab_prev_d = BANK_AB_DIM_INPUT;
    c_prev_d  = BANK_C_DIM_INPUT;
    any_in    = BANK_AB_DIM_INPUT | BANK_C_DIM_INPUT;
    // hold timers restart on every edge of their input
    ab_hold_d = (BANK_AB_DIM_INPUT != ab_prev_q) ? `CNT_ZERO :
                (ab_hold_q < SHUT_LIM) ? ab_hold_q + 1'b1 : ab_hold_q;
    c_hold_d  = (BANK_C_DIM_INPUT != c_prev_q) ? `CNT_ZERO :
                (c_hold_q < SHUT_LIM) ? c_hold_q + 1'b1 : c_hold_q;
    case (state_q)
      ST_RESET:
      begin
        pur_d = pur_q + 1'b1;
        if (pur_q >= PUR_LIM - 1'b1)
          state_d = ST_SHUT;
      end
      ST_SHUT:
      begin
        idle_d = `CNT_ZERO;
        filt_d = `CNT_ZERO;
        mode_d = PM_1X;
        if (any_in && !UVLO)
          state_d = ST_RUN;
      end
      ST_RUN:
      begin
        idle_d = any_in ? `CNT_ZERO : idle_q + 1'b1;
        if (UVLO)
          state_d = ST_SHUT;
        else if (!any_in && idle_q >= SHUT_LIM)
          state_d = ST_SHUT;
        // supply comparator carries the 600 mV hysteresis itself
        if (mode_q != PM_1X && SUPPLY_OK_1X)
        begin
          mode_d = PM_1X;
          filt_d = `CNT_ZERO;
        end
        else if (low_hr && mode_q != PM_2X)
        begin
          if (filt_q >= FILT_LIM - 1'b1)
          begin
            filt_d = `CNT_ZERO;
            case (mode_q)
              PM_1X:   mode_d = PM_133X;
              PM_133X: mode_d = PM_15X;
              default: mode_d = PM_2X;
            endcase
          end
          else
            filt_d = filt_q + 1'b1;
        end
        else
          filt_d = `CNT_ZERO;
      end
      default: state_d = ST_RESET;
    endcase
    en_d = (state_d == ST_RUN) ? bank_on : 6'h00;
    oe_d = (state_d == ST_RUN) ? 6'h3F : 6'h00;
  end

  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q   <= ST_RESET;
      mode_q    <= PM_1X;
      idle_q    <= `CNT_ZERO;
      ab_hold_q <= `CNT_ZERO;
      c_hold_q  <= `CNT_ZERO;
      filt_q    <= `CNT_ZERO;
      pur_q     <= `PUR_ZERO;
      ab_prev_q <= 1'b0;
      c_prev_q  <= 1'b0;
      en_q      <= 6'h00;
      oe_q      <= 6'h00;
    end
    else if (CE)
    begin
      state_q   <= state_d;
      mode_q    <= mode_d;
      idle_q    <= idle_d;
      ab_hold_q <= ab_hold_d;
      c_hold_q  <= c_hold_d;
      filt_q    <= filt_d;
      pur_q     <= pur_d;
      ab_prev_q <= ab_prev_d;
      c_prev_q  <= c_prev_d;
      en_q      <= en_d;
      oe_q      <= oe_d;
    end
  end

  logic shut_q, shut_d;
  logic pump_q, pump_d;

  // flags follow the next state so they change on the same edge as the cathodes
  always_comb
  begin
    shut_d = (state_d != ST_RUN);
    pump_d = (state_d == ST_RUN);
  end

  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      shut_q <= 1'b1;
      pump_q <= 1'b0;
    end
    else if (CE)
    begin
      shut_q <= shut_d;
      pump_q <= pump_d;
    end
  end

  assign CATHODE_EN = en_q;
  assign CATHODE_OE = oe_q;
  assign PUMP_MODE  = mode_q;
  assign PUMP_ON    = pump_q;
  assign SHUTDOWN   = shut_q;

  uvlo_shut_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (CE && UVLO) |=> SHUTDOWN && CATHODE_OE == 6'h00)
    else $error("undervoltage did not shut down");
  hiz_shut_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    SHUTDOWN |-> CATHODE_OE == 6'h00 && CATHODE_EN == 6'h00)
    else $error("cathodes driven in shutdown");
  wake_up_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (CE && state_q == ST_SHUT && any_in && !UVLO) |=> !SHUTDOWN && PUMP_MODE == `MODE_1X)
    else $error("wake up not in 1-x");
  bank_gate_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (CE && state_d == ST_RUN) |=> CATHODE_EN[5:4] == {2{$past(c_live)}}
      && CATHODE_EN[3:0] == {4{$past(ab_live)}})
    else $error("bank gating wrong");
  no_step_2x_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    ($past(PUMP_MODE) == `MODE_2X && PUMP_MODE != `MODE_2X) |-> PUMP_MODE == `MODE_1X)
    else $error("step beyond 2-x");
  step_order_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    ($past(PUMP_MODE) == `MODE_133X && PUMP_MODE != `MODE_133X)
      |-> PUMP_MODE == `MODE_15X || PUMP_MODE == `MODE_1X)
    else $error("illegal mode order");
  step_filter_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (PUMP_MODE != `MODE_1X && $past(PUMP_MODE) != PUMP_MODE && !$past(SUPPLY_OK_1X))
      |-> $past(filt_q) == FILT_LIM - 1'b1)
    else $error("step without filter delay");
  idle_shut_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (CE && state_q == ST_RUN && !any_in && !UVLO && idle_q < SHUT_LIM) |=> !SHUTDOWN)
    else $error("early shutdown");

  // power-up reset interval and its quiet outputs
  pur_len_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (state_q == ST_RESET) |-> pur_q < PUR_LIM)
    else $error("power-up reset overran");
  pur_quiet_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (state_q == ST_RESET) |-> SHUTDOWN && !PUMP_ON && CATHODE_OE == 6'h00)
    else $error("outputs active in power-up reset");

  // running state flags and pins
  pump_flag_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    PUMP_ON != SHUTDOWN)
    else $error("pump flag disagrees with shutdown");
  oe_run_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    !SHUTDOWN |-> CATHODE_OE == 6'h3F)
    else $error("cathode left high impedance while running");
  stuck_off_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (CE && ab_hold_q >= SHUT_LIM && BANK_AB_DIM_INPUT == ab_prev_q)
      |=> CATHODE_EN[3:0] == 4'h0)
    else $error("stuck input kept bank on");

  // mode sequencing
  mode_shut_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (CE && state_q == ST_SHUT) |=> PUMP_MODE == `MODE_1X)
    else $error("shutdown left pump out of 1-x");
  ret_1x_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (CE && state_q == ST_RUN && SUPPLY_OK_1X && PUMP_MODE != `MODE_1X)
      |=> PUMP_MODE == `MODE_1X)
    else $error("no direct return to 1-x");
  hold_mode_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (CE && state_q == ST_RUN && !SUPPLY_OK_1X && !low_hr) |=> $stable(PUMP_MODE))
    else $error("mode moved without low headroom");

  // a low enable must hold pump mode, shutdown and the cathode enables where they were
  freeze_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
    !CE |=> $stable(PUMP_MODE) && $stable(SHUTDOWN) && $stable(CATHODE_EN))
    else $error("state moved while clock enable low");
endmodule
